// ==== sdm_dma_engine.sv ====
// shared-ram bus dma engine: register file, burst sequencer, mastership
// Behaviour
// RULE1: stage data in eight 4-byte buffer entries
// RULE2: burst is eight reads then eight writes
// RULE3: request and await grant before shared-ram cycles
// RULE4: release vme before writing burst to ram
// RULE5: hold cpu vme access until buffer empties
// RULE6: free local cpu between shared-ram bursts
// RULE7: vme-to-vme moves take no local cycles
// RULE8: move between vsb, vme, ram any pairing
// RULE9: narrow beats until aligned, then 32-bit
// RULE10: 8-bit irq control and attribute registers
// RULE11: 8-bit irq status, run, mode registers
// RULE12: master the buses without cpu help
// RULE13: count down on writes, complete, interrupt
// RULE14: bus error aborts, flags, interrupts
//
// The placing of the registers and strobed register access are this design's own decisions.
`default_nettype none
module sdm_dma_engine #(
   parameter int DEPTH = sdm_pkg::FIFO_DEPTH
) (
   input  wire logic                        mclk,
   input  wire logic                        resetn,
   input  wire logic [sdm_pkg::AW-1:0]      reg_addr,
   input  wire logic [sdm_pkg::DW-1:0]      reg_wdata,
   input  wire logic                        reg_we,
   input  wire logic                        reg_re,
   output var  logic [sdm_pkg::DW-1:0]      reg_rdata,
   output var  logic [sdm_pkg::NAREA-1:0]   mst_req,
   input  wire logic [sdm_pkg::NAREA-1:0]   mst_gnt,
   output var  logic                        bus_req,
   output var  logic [1:0]                  bus_area,
   output var  logic [sdm_pkg::DW-1:0]      bus_addr,
   output var  logic [sdm_pkg::SZW-1:0]     bus_size,
   output var  logic                        bus_we,
   output var  logic [sdm_pkg::DW-1:0]      bus_wdata,
   input  wire logic [sdm_pkg::DW-1:0]      bus_rdata,
   input  wire logic                        bus_ack,
   input  wire logic                        bus_err,
   output var  logic                        cpu_vme_hold,
   output var  logic                        irq
);
   import sdm_pkg::*;

   localparam int LW = $clog2(DEPTH + 1);

   logic [7:0]     irq_ctrl_normal_end;
   logic [7:0]     irq_ctrl_error_end;
   logic [7:0]     source_attributes;
   logic [7:0]     destination_attributes;
   logic [7:0]     general_control;
   logic [7:0]     irq_status_normal_end;
   logic [7:0]     irq_status_error_end;
   logic [7:0]     run_control;
   logic [7:0]     mode_state;
   logic [DW-1:0]  source_pointer;
   logic [DW-1:0]  destination_pointer;
   logic [DW-1:0]  transfer_length;
   logic [DW-1:0]  rd_left;
   logic [DW-1:0]  dst_ahead;
   logic [DW-1:0]  cur_bytes;
   logic [3:0]     beat_cnt;
   logic [1:0]     src_area;
   logic [1:0]     dst_area;
   logic [SZW-1:0] next_size;
   sdm_state_t     state;
   logic           busy;
   logic           go;
   logic           abort;
   logic           err;
   logic           rd_go;
   logic           wr_go;
   logic           rd_last;
   logic           xfer_last;

   sdm_fifo_if #(.W(ENTRY_W), .LW(LW)) f ();

   sdm_stage_fifo #(
      .W     (ENTRY_W),
      .DEPTH (DEPTH),
      .LW    (LW)
   ) u_fifo (
      .mclk   (mclk),
      .resetn (resetn),
      .f      (f.store)
   );

   // bytes moved by one beat of the given size
   function automatic logic [DW-1:0] sz_bytes(input logic [SZW-1:0] sz);
      unique case (sz)
         SZ_WORD: return 32'h0000_0004;
         SZ_HALF: return 32'h0000_0002;
         default: return 32'h0000_0001;
      endcase
   endfunction : sz_bytes

   // widest beat allowed by both addresses and the bytes left
   function automatic logic [SZW-1:0] pick_size(input logic [1:0] lo,
                                                 input logic [DW-1:0] left);
      if (lo == 2'h0 && left >= 32'h0000_0004)
         return SZ_WORD;
      else if (!lo[0] && left >= 32'h0000_0002)
         return SZ_HALF;
      else
         return SZ_BYTE;
   endfunction : pick_size

   // area decode, reserved code falls back to the secondary bus
   assign src_area  = (source_attributes[ATTR_AREA_LSB +: 2] == 2'h3) ? AREA_VSB
                      : source_attributes[ATTR_AREA_LSB +: 2]; // RULE8
   assign dst_area  = (destination_attributes[ATTR_AREA_LSB +: 2] == 2'h3) ? AREA_VSB
                      : destination_attributes[ATTR_AREA_LSB +: 2]; // RULE8
   assign next_size = pick_size(source_pointer[1:0] | dst_ahead[1:0], rd_left); // RULE9
   assign cur_bytes = sz_bytes(bus_size);

   // sequencer decisions
   assign busy      = (state != ST_IDLE);
   assign go        = reg_we && reg_addr == OFS_RUN_CTRL && reg_wdata[RUN_GO_BIT]
                      && general_control[GEN_EN_BIT] && !busy;
   assign abort     = reg_we && reg_addr == OFS_RUN_CTRL && reg_wdata[RUN_ABORT_BIT] && busy;
   assign err       = (state == ST_RD_BEAT || state == ST_WR_BEAT) && bus_err; // RULE14
   // a grant counts only once our own request is out, so a stale one is ignored
   assign rd_go     = state == ST_RD_REQ && mst_req[src_area] && mst_gnt[src_area]
                      && f.in_ready; // RULE3
   assign wr_go     = state == ST_WR_REQ && mst_req[dst_area] && mst_gnt[dst_area]
                      && f.out_valid; // RULE3
   assign rd_last   = (beat_cnt == 4'(BURST_BEATS - 1)) || (rd_left == cur_bytes); // RULE2
   assign xfer_last = (transfer_length == cur_bytes);

   // buffer handshake
   assign f.push    = state == ST_RD_BEAT && bus_ack && !bus_err; // RULE1
   assign f.in_data = {bus_size, bus_rdata};
   assign f.pop     = wr_go;
   assign f.flush   = err || abort;
   assign mode_state = {busy, 3'h0, 4'(f.level)}; // RULE11

   // burst sequencer, bus master and address/count registers
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         state               <= ST_IDLE;
         source_pointer      <= RST_WORD;
         destination_pointer <= RST_WORD;
         transfer_length     <= RST_WORD;
         rd_left             <= RST_WORD;
         dst_ahead           <= RST_WORD;
         beat_cnt            <= 4'h0;
         mst_req             <= '0;
         bus_req             <= 1'b0;
         bus_area            <= AREA_SRAM;
         bus_addr            <= RST_WORD;
         bus_size            <= SZ_BYTE;
         bus_we              <= 1'b0;
         bus_wdata           <= RST_WORD;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (reg_we && reg_addr == OFS_SRC_PTR)
                  source_pointer <= reg_wdata;
               if (reg_we && reg_addr == OFS_DST_PTR)
                  destination_pointer <= reg_wdata;
               if (reg_we && reg_addr == OFS_XFER_LEN)
                  transfer_length <= reg_wdata;
               if (go)
               begin
                  rd_left   <= transfer_length;
                  dst_ahead <= destination_pointer;
                  beat_cnt  <= 4'h0;
                  state     <= (transfer_length == RST_WORD) ? ST_DONE : ST_RD_REQ;
               end
            end
            ST_RD_REQ:
            begin
               mst_req <= NAREA'(1) << src_area; // RULE7 RULE12
               if (rd_go)
               begin
                  bus_area <= src_area;
                  bus_addr <= source_pointer;
                  bus_size <= next_size; // RULE9
                  bus_we   <= 1'b0;
                  bus_req  <= 1'b1;
                  state    <= ST_RD_BEAT;
               end
            end
            ST_RD_BEAT:
            begin
               if (bus_ack)
               begin
                  bus_req        <= 1'b0;
                  source_pointer <= source_pointer + cur_bytes;
                  dst_ahead      <= dst_ahead + cur_bytes;
                  rd_left        <= rd_left - cur_bytes;
                  beat_cnt       <= beat_cnt + 4'h1;
                  if (rd_last)
                  begin
                     mst_req <= '0; // RULE4
                     state   <= ST_WR_REQ; // RULE2
                  end
                  else
                     state <= ST_RD_REQ;
               end
            end
            ST_WR_REQ:
            begin
               mst_req <= NAREA'(1) << dst_area; // RULE12
               if (wr_go)
               begin
                  bus_area  <= dst_area;
                  bus_addr  <= destination_pointer;
                  bus_size  <= f.out_data[DW +: SZW];
                  bus_wdata <= f.out_data[DW-1:0];
                  bus_we    <= 1'b1;
                  bus_req   <= 1'b1;
                  state     <= ST_WR_BEAT;
               end
            end
            ST_WR_BEAT:
            begin
               if (bus_ack)
               begin
                  bus_req             <= 1'b0;
                  bus_we              <= 1'b0;
                  destination_pointer <= destination_pointer + cur_bytes;
                  transfer_length     <= transfer_length - cur_bytes; // RULE13
                  if (!f.out_valid)
                  begin
                     mst_req  <= '0; // RULE6
                     beat_cnt <= 4'h0;
                     state    <= xfer_last ? ST_DONE : ST_RD_REQ; // RULE13
                  end
                  else
                     state <= ST_WR_REQ;
               end
            end
            ST_DONE:
            begin
               state <= ST_IDLE;
            end
         endcase
         // error or software abort drops every request
         if (err || abort)
         begin
            bus_req <= 1'b0;
            bus_we  <= 1'b0;
            mst_req <= '0;
            state   <= ST_IDLE; // RULE14
         end
      end
   end

   // control and attribute registers, attributes fixed while busy
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         irq_ctrl_normal_end    <= RST_BYTE;
         irq_ctrl_error_end     <= RST_BYTE;
         source_attributes      <= RST_BYTE;
         destination_attributes <= RST_BYTE;
         general_control        <= RST_BYTE;
         run_control            <= RST_BYTE;
      end
      else if (reg_we)
      begin
         unique case (reg_addr)
            OFS_ICTL_NRM: irq_ctrl_normal_end <= reg_wdata[7:0]; // RULE10
            OFS_ICTL_ERR: irq_ctrl_error_end <= reg_wdata[7:0]; // RULE10
            OFS_SRC_ATTR: if (!busy) source_attributes <= reg_wdata[7:0]; // RULE10
            OFS_DST_ATTR: if (!busy) destination_attributes <= reg_wdata[7:0]; // RULE10
            OFS_GEN_CTRL: general_control <= reg_wdata[7:0];
            OFS_RUN_CTRL: run_control <= reg_wdata[7:0]; // RULE11
            default: ;
         endcase
      end
   end

   // sticky completion flags, write one to clear, a new event wins
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         irq_status_normal_end <= RST_BYTE;
         irq_status_error_end  <= RST_BYTE;
      end
      else
      begin
         irq_status_normal_end <= (irq_status_normal_end
            & ~((reg_we && reg_addr == OFS_IST_NRM) ? reg_wdata[7:0] : 8'h00))
            | (8'(state == ST_DONE) << IRQ_EVENT_BIT); // RULE13
         irq_status_error_end  <= (irq_status_error_end
            & ~((reg_we && reg_addr == OFS_IST_ERR) ? reg_wdata[7:0] : 8'h00))
            | (8'(err) << IRQ_EVENT_BIT); // RULE14
      end
   end

   // interrupt line and cpu hold-off
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         irq          <= 1'b0;
         cpu_vme_hold <= 1'b0;
      end
      else
      begin
         irq          <= |(irq_status_normal_end & irq_ctrl_normal_end)
                         | |(irq_status_error_end & irq_ctrl_error_end); // RULE11
         cpu_vme_hold <= f.out_valid; // RULE5
      end
   end

   // read data, one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk)
   begin
      if (!resetn || !reg_re)
         reg_rdata <= RST_WORD;
      else
      begin
         unique case (reg_addr)
            OFS_ICTL_NRM: reg_rdata <= {24'h0, irq_ctrl_normal_end};
            OFS_ICTL_ERR: reg_rdata <= {24'h0, irq_ctrl_error_end};
            OFS_SRC_ATTR: reg_rdata <= {24'h0, source_attributes};
            OFS_DST_ATTR: reg_rdata <= {24'h0, destination_attributes};
            OFS_GEN_CTRL: reg_rdata <= {24'h0, general_control};
            OFS_IST_NRM:  reg_rdata <= {24'h0, irq_status_normal_end};
            OFS_IST_ERR:  reg_rdata <= {24'h0, irq_status_error_end};
            OFS_RUN_CTRL: reg_rdata <= {24'h0, run_control[7:1], busy};
            OFS_MODE_ST:  reg_rdata <= {24'h0, mode_state};
            OFS_SRC_PTR:  reg_rdata <= source_pointer;
            OFS_DST_PTR:  reg_rdata <= destination_pointer;
            OFS_XFER_LEN: reg_rdata <= transfer_length;
            default:      reg_rdata <= RST_WORD;
         endcase
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence wr_burst_end;
      state == ST_WR_BEAT && bus_ack && !bus_err && !f.out_valid;
   endsequence
   sequence done_seen;
      state == ST_DONE;
   endsequence

   a_burst_beats: assert property ( // RULE2
      beat_cnt <= 4'(BURST_BEATS)) else $error("burst longer than eight beats");
   a_sram_grant: assert property ( // RULE3
      $rose(bus_req) && bus_area == AREA_SRAM |-> $past(mst_req[AREA_SRAM] && mst_gnt[AREA_SRAM]))
      else $error("ram cycle without grant");
   a_vme_free: assert property ( // RULE4
      state == ST_WR_REQ && src_area == AREA_VME && dst_area == AREA_SRAM
      |-> !mst_req[AREA_VME]) else $error("vme held while writing ram");
   a_cpu_hold: assert property ( // RULE5
      f.out_valid |=> cpu_vme_hold) else $error("cpu not held with data buffered");
   a_release_gap: assert property ( // RULE6
      wr_burst_end |=> mst_req == '0) else $error("mastership kept after burst");
   a_no_local: assert property ( // RULE7
      busy && src_area == AREA_VME && dst_area == AREA_VME |-> !mst_req[AREA_SRAM])
      else $error("local cycles taken in vme move");
   a_word_align: assert property ( // RULE9
      bus_req && bus_size == SZ_WORD |-> bus_addr[1:0] == 2'h0)
      else $error("unaligned word beat");
   a_done_flag: assert property ( // RULE13
      done_seen |=> irq_status_normal_end[IRQ_EVENT_BIT] && state == ST_IDLE)
      else $error("completion not flagged");
   a_err_abort: assert property ( // RULE14
      err |=> state == ST_IDLE && irq_status_error_end[IRQ_EVENT_BIT] && !bus_req)
      else $error("bus error not aborted");
   a_irq_level: assert property ( // RULE11
      ##1 irq == $past(|(irq_status_normal_end & irq_ctrl_normal_end)
                       | |(irq_status_error_end & irq_ctrl_error_end)))
      else $error("interrupt line wrong");
endmodule : sdm_dma_engine
`default_nettype wire

// ==== sdm_far_model.sv ====
// far side of the engine: mastership grants, bus slaves with memory, fault injection
`default_nettype none
module sdm_far_model (
   input  wire logic                mclk,
   input  wire logic                resetn,
   input  wire logic [2:0]          mst_req,
   output var  logic [2:0]          mst_gnt,
   input  wire logic                bus_req,
   input  wire logic [1:0]          bus_area,
   input  wire logic [31:0]         bus_addr,
   input  wire logic [1:0]          bus_size,
   input  wire logic                bus_we,
   input  wire logic [31:0]         bus_wdata,
   output var  logic [31:0]         bus_rdata,
   output var  logic                bus_ack,
   output var  logic                bus_err,
   input  wire logic [3:0]          gdly,
   input  wire logic [3:0]          adly,
   input  wire logic [15:0]         err_at
);
   timeunit 1ns;
   timeprecision 1ns;
   import sdm_pkg::*;
   logic [31:0] mem [0:2][0:31];
   logic [15:0] beats = 16'h0;
   logic [3:0]  gcnt;
   logic [3:0]  acnt;
   // grant only after the request has stood gdly cycles
   always @(posedge mclk)
   begin
      if (!resetn || mst_req == 3'h0)
      begin
         mst_gnt <= 3'h0;
         gcnt    <= 4'h0;
      end
      else if (gcnt < gdly)
         gcnt <= gcnt + 4'h1;
      else
         mst_gnt <= mst_req;
   end
   // one answer per beat after adly cycles; idle data lines toggle
   always @(posedge mclk)
   begin
      if (!resetn || bus_ack || bus_err || !bus_req)
      begin
         bus_ack   <= 1'b0;
         bus_err   <= 1'b0;
         acnt      <= 4'h0;
         bus_rdata <= (bus_rdata === 32'hX) ? 32'h0 : ~bus_rdata;
      end
      else if (acnt < adly)
         acnt <= acnt + 4'h1;
      else
      begin
         beats   <= beats + 16'h1;
         bus_err <= (beats + 16'h1 == err_at);
         bus_ack <= (beats + 16'h1 != err_at);
         if (bus_we && bus_size == SZ_WORD)
            mem[bus_area][bus_addr[6:2]] <= bus_wdata;
         if (!bus_we)
            bus_rdata <= mem[bus_area][bus_addr[6:2]] >> (8 * bus_addr[1:0]);
      end
   end
endmodule : sdm_far_model
`default_nettype wire

// ==== sdm_fifo_if.sv ====
// interface between the engine and its staging buffer
`default_nettype none
interface sdm_fifo_if #(
   parameter int W  = 34,
   parameter int LW = 4
);
   logic          push;
   logic          in_ready;
   logic [W-1:0]  in_data;
   logic          pop;
   logic          out_valid;
   logic [W-1:0]  out_data;
   logic          flush;
   logic [LW-1:0] level;
   modport eng   (output push, in_data, pop, flush, input in_ready, out_valid, out_data, level);
   modport store (input push, in_data, pop, flush, output in_ready, out_valid, out_data, level);
endinterface : sdm_fifo_if
`default_nettype wire

// ==== sdm_pkg.sv ====
// constants, types and register map of the shared-ram bus dma engine
`default_nettype none
package sdm_pkg;
   localparam int ENTRY_BYTES  = 4;
   localparam int DW           = 8 * ENTRY_BYTES;
   localparam int AW           = 6;
   localparam int FIFO_DEPTH   = 8;
   localparam int BURST_BEATS  = 8;
   localparam int SZW          = 2;
   localparam int ENTRY_W      = DW + SZW;
   localparam int NAREA        = 3;
   // register byte offsets
   localparam logic [AW-1:0] OFS_ICTL_NRM = 6'h00;
   localparam logic [AW-1:0] OFS_ICTL_ERR = 6'h04;
   localparam logic [AW-1:0] OFS_SRC_ATTR = 6'h08;
   localparam logic [AW-1:0] OFS_DST_ATTR = 6'h0C;
   localparam logic [AW-1:0] OFS_GEN_CTRL = 6'h10;
   localparam logic [AW-1:0] OFS_IST_NRM  = 6'h14;
   localparam logic [AW-1:0] OFS_IST_ERR  = 6'h18;
   localparam logic [AW-1:0] OFS_RUN_CTRL = 6'h1C;
   localparam logic [AW-1:0] OFS_MODE_ST  = 6'h20;
   localparam logic [AW-1:0] OFS_SRC_PTR  = 6'h24;
   localparam logic [AW-1:0] OFS_DST_PTR  = 6'h28;
   localparam logic [AW-1:0] OFS_XFER_LEN = 6'h2C;
   // field positions
   localparam int ATTR_AREA_LSB = 0;
   localparam int GEN_EN_BIT    = 0;
   localparam int RUN_GO_BIT    = 0;
   localparam int RUN_ABORT_BIT = 1;
   localparam int IRQ_EVENT_BIT = 0;
   localparam int MODE_BUSY_BIT = 7;
   // area codes
   localparam logic [1:0] AREA_SRAM = 2'h0;
   localparam logic [1:0] AREA_VME  = 2'h1;
   localparam logic [1:0] AREA_VSB  = 2'h2;
   // beat sizes, bytes = 1 << size
   localparam logic [SZW-1:0] SZ_BYTE = 2'h0;
   localparam logic [SZW-1:0] SZ_HALF = 2'h1;
   localparam logic [SZW-1:0] SZ_WORD = 2'h2;
   // reset values
   localparam logic [7:0]    RST_BYTE = 8'h00;
   localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_REQ,
      ST_RD_BEAT,
      ST_WR_REQ,
      ST_WR_BEAT,
      ST_DONE
   } sdm_state_t;
endpackage : sdm_pkg
`default_nettype wire

// ==== sdm_stage_fifo.sv ====
// staging buffer of the dma engine
`default_nettype none
module sdm_stage_fifo #(
   parameter int W     = 34,
   parameter int DEPTH = 8,
   parameter int LW    = 4
) (
   input wire logic mclk,
   input wire logic resetn,
   sdm_fifo_if.store f
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   logic [LW-1:0] cnt;
   logic          do_push;
   logic          do_pop;

   // handshake and head of queue
   assign f.in_ready  = (cnt != LW'(DEPTH));
   assign f.out_valid = (cnt != '0);
   assign f.out_data  = mem[rp];
   assign f.level     = cnt;
   assign do_push     = f.push && f.in_ready;
   assign do_pop      = f.pop && f.out_valid;

   // storage array
   always_ff @(posedge mclk)
   begin
      if (do_push)
      begin
         mem[wp] <= f.in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge mclk)
   begin
      if (!resetn || f.flush)
      begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end
      else
      begin
         if (do_push)
            wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + PW'(1);
         if (do_pop)
            rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + PW'(1);
         if (do_push && !do_pop)
            cnt <= cnt + LW'(1);
         else if (do_pop && !do_push)
            cnt <= cnt - LW'(1);
      end
   end

   a_no_overflow: assert property (@(posedge mclk) disable iff (!resetn)
      f.push |-> f.in_ready) else $error("push into full buffer"); // RULE1
   a_level_bound: assert property (@(posedge mclk) disable iff (!resetn)
      cnt <= LW'(DEPTH)) else $error("buffer level above depth"); // RULE1
endmodule : sdm_stage_fifo
`default_nettype wire

// ==== tb.sv ====
// self-checking bench of the dma engine: register calls and transfer runs
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sdm_pkg::*;
   logic          mclk, resetn, reg_we, reg_re, bus_req, bus_we, bus_ack, bus_err;
   logic          cpu_vme_hold, irq, prev0, bad3, bad4, bad6, saw_hold;
   logic [AW-1:0] reg_addr;
   logic [31:0]   reg_wdata, reg_rdata, bus_addr, bus_wdata, bus_rdata;
   logic [2:0]    mst_req, mst_gnt;
   logic [1:0]    bus_area, bus_size;
   logic [3:0]    gdly, adly;
   logic [15:0]   err_at;
   logic          weq[$];
   logic [1:0]    szq[$];
   int            err_count, checks, nram;
   sdm_dma_engine #(.DEPTH(FIFO_DEPTH)) dut (.mclk(mclk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .mst_req(mst_req), .mst_gnt(mst_gnt), .bus_req(bus_req),
      .bus_area(bus_area), .bus_addr(bus_addr), .bus_size(bus_size), .bus_we(bus_we),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
      .cpu_vme_hold(cpu_vme_hold), .irq(irq));
   sdm_far_model u_far (.mclk(mclk), .resetn(resetn), .mst_req(mst_req), .mst_gnt(mst_gnt),
      .bus_req(bus_req), .bus_area(bus_area), .bus_addr(bus_addr), .bus_size(bus_size),
      .bus_we(bus_we), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
      .bus_err(bus_err), .gdly(gdly), .adly(adly), .err_at(err_at));
   // clock
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // beat log and mastership watch
   always @(posedge mclk)
   begin
      if (resetn && bus_req && bus_ack)
      begin
         weq.push_back(bus_we);
         if (!bus_we)
            szq.push_back(bus_size);
      end
      if (bus_req && mst_gnt[bus_area] !== 1'b1)
         bad3 = 1'b1;
      if (bus_req && bus_we && bus_area == AREA_SRAM && mst_req[1])
         bad4 = 1'b1;
      if (bus_req && bus_area != AREA_SRAM && mst_req[0])
         bad6 = 1'b1;
      if (mst_req[0] && !prev0)
         nram++;
      prev0 = mst_req[0];
      if (cpu_vme_hold)
         saw_hold = 1'b1;
   end
   function automatic logic [31:0] pv(input int i);
      return {16'hA5A5, 11'h0, i[4:0]};
   endfunction : pv
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= 1'b1;
      @(posedge mclk);
      reg_we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [AW-1:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_re   <= 1'b1;
      @(posedge mclk);
      reg_re <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd
   task automatic rc(input logic [AW-1:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(v, e);
   endtask : rc
   // program a move, start it and poll until the engine is idle
   task automatic go(input logic [1:0] sa, input logic [31:0] sp, input logic [1:0] da,
                     input logic [31:0] dp, input logic [31:0] n);
      logic [31:0] v;
      weq.delete();
      szq.delete();
      {bad3, bad4, bad6, saw_hold, nram} = '0;
      wr(OFS_SRC_ATTR, {30'h0, sa});
      wr(OFS_DST_ATTR, {30'h0, da});
      wr(OFS_SRC_PTR, sp);
      wr(OFS_DST_PTR, dp);
      wr(OFS_XFER_LEN, n);
      wr(OFS_RUN_CTRL, 32'h1);
      for (int i = 0; i < 500; i++)
      begin
         rd(OFS_MODE_ST, v);
         if (v[MODE_BUSY_BIT] === 1'b0)
            break;
      end
      chk({31'h0, v[MODE_BUSY_BIT]}, 32'h0);
   endtask : go
   task automatic end_of_test;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   // watchdog
   initial
   begin
      #3_000_000;
      err_count++;
      end_of_test();
   end
   // main sequence
   initial
   begin
      logic [15:0] pat;
      {resetn, reg_we, reg_re, reg_addr, reg_wdata, err_at} = '0;
      {gdly, adly} = {4'h4, 4'h2};
      for (int i = 0; i < 32; i++)
         {u_far.mem[0][i], u_far.mem[1][i], u_far.mem[2][i]} = {32'h0, pv(i), 32'h0};
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      for (int a = 0; a <= 48; a += 4)
         rc(a[AW-1:0], 32'h0);
      wr(OFS_ICTL_ERR, 32'hFFFF_FF5A);
      rc(OFS_ICTL_ERR, 32'h0000_005A);
      wr(OFS_MODE_ST, 32'h0000_00FF);
      rc(OFS_MODE_ST, 32'h0);
      wr(6'h30, 32'hFFFF_FFFF);
      rc(6'h30, 32'h0);
      wr(OFS_DST_PTR, 32'h89AB_CDEF);
      rc(OFS_DST_PTR, 32'h89AB_CDEF);
      wr(OFS_GEN_CTRL, 32'h1);
      wr(OFS_ICTL_NRM, 32'h1);
      wr(OFS_ICTL_ERR, 32'h0);
      // slow partner, two bursts from vme into shared ram
      go(AREA_VME, 32'h0, AREA_SRAM, 32'h20, 32'd40);
      for (int i = 0; i < 16; i++)
         pat[15-i] = weq[i];
      chk({16'h0, pat}, 32'h0000_00FF);
      chk(weq.size(), 32'd20);
      chk(bad4, 1'b0);
      chk(bad3, 1'b0);
      chk(bad6, 1'b0);
      chk(nram, 32'd2);
      chk(saw_hold, 1'b1);
      chk(cpu_vme_hold, 1'b0);
      for (int i = 0; i < 10; i++)
         chk(u_far.mem[0][8+i], pv(i));
      rc(OFS_XFER_LEN, 32'h0);
      rc(OFS_IST_NRM, 32'h1);
      chk(irq, 1'b1);
      wr(OFS_IST_NRM, 32'h1);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      // prompt partner, vme to vme, then shared ram to vsb
      {gdly, adly} = 8'h00;
      go(AREA_VME, 32'h0, AREA_VME, 32'h20, 32'd16);
      chk(nram, 32'd0);
      for (int i = 0; i < 4; i++)
         chk(u_far.mem[1][8+i], pv(i));
      go(AREA_SRAM, 32'h20, AREA_VSB, 32'h0, 32'd8);
      chk(u_far.mem[2][1], pv(1));
      // unaligned start: byte, half, then word beats
      go(AREA_SRAM, 32'h1, AREA_VME, 32'h1, 32'd7);
      chk({26'h0, szq[0], szq[1], szq[2]}, {26'h0, SZ_BYTE, SZ_HALF, SZ_WORD});
      rc(OFS_XFER_LEN, 32'h0);
      // zero length completes at once; flag cleared before the error run
      wr(OFS_IST_NRM, 32'h1);
      go(AREA_SRAM, 32'h0, AREA_VME, 32'h0, 32'h0);
      chk(weq.size(), 32'd0);
      rc(OFS_IST_NRM, 32'h1);
      wr(OFS_IST_NRM, 32'h1);
      // bus error on the third beat, error interrupt masked then enabled
      err_at = u_far.beats + 16'd3;
      go(AREA_VME, 32'h0, AREA_SRAM, 32'h40, 32'd32);
      rc(OFS_IST_ERR, 32'h1);
      chk(irq, 1'b0);
      chk({cpu_vme_hold, mst_req}, 4'h0);
      wr(OFS_ICTL_ERR, 32'h1);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b1);
      wr(OFS_IST_ERR, 32'h1);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      // software abort while the grant is still pending, no status raised
      {gdly, adly} = 8'hFF;
      wr(OFS_RUN_CTRL, 32'h1);
      wr(OFS_RUN_CTRL, 32'h2);
      rc(OFS_MODE_ST, 32'h0);
      rc(OFS_IST_ERR, 32'h0);
      chk({cpu_vme_hold, mst_req}, 4'h0);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
